//--- logic/serial_pin_pkg.sv
// Constants shared by the serial and modem pin logic.
// Assumes a 32-bit Avalon-MM register bus with byte addressing.
package serial_pin_pkg;
	localparam int ADDR_W     = 6;
	localparam int DATA_W     = 32;
	localparam int CHANNELS   = 2;
	// Register index within a channel, address bits [4:2]; bit 5 picks the channel
	localparam logic [2:0] REG_TX_DATA  = 3'h0;
	localparam logic [2:0] REG_MODEM    = 3'h1;
	localparam logic [2:0] REG_FEATURE  = 3'h2;
	localparam logic [2:0] REG_ENHANCED = 3'h3;
	localparam logic [2:0] REG_EXTMODE  = 3'h4;
	localparam logic [2:0] REG_STATUS   = 3'h5;
	localparam int CHAN_BIT   = 5;
	// Modem control fields
	localparam int MC_TERM_READY = 0;
	localparam int MC_REQ_SEND   = 1;
	localparam int MC_USER_OUT   = 3;
	localparam int MC_IR_SELECT  = 6;
	// Feature control fields
	localparam int FC_RX_INVERT  = 2;
	localparam int FC_AUTO_DIR   = 3;
	// Enhanced feature fields
	localparam int EF_AUTO_RTS   = 6;
	localparam int EF_AUTO_CTS   = 7;
	// Extended mode fields
	localparam int EM_DIR_INVERT = 3;
	// Status fields
	localparam int ST_CTS    = 0;
	localparam int ST_DSR    = 1;
	localparam int ST_CD     = 2;
	localparam int ST_RI     = 3;
	localparam int ST_RX     = 4;
	localparam int ST_BUSY   = 5;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Transmit timing
	localparam int BIT_CYCLES  = 16;
	localparam int IR_PULSE    = (BIT_CYCLES * 3 / 16 < 1) ? 1 : BIT_CYCLES * 3 / 16;
	localparam int FRAME_BITS  = 10;
	localparam int FIFO_DEPTH  = 8;
	localparam int FIFO_WIDTH  = 8;
	typedef enum logic [0:0] {
		TX_IDLE  = 1'b0,
		TX_SHIFT = 1'b1
	} tx_state_t;
endpackage

//--- logic/uart_serial_modem_pin_logic.sv
// Serial and modem pin logic of two channels, with a small transmit path per channel.
// Assumes an Avalon-MM master, pins synchronous to clock, and channel interrupts
// generated elsewhere and fed in on irq_in_chN.
//
// Operation
// - Infrared select clear means plain serial transmit and receive path.
// - Plain mode transmit pin sits high in reset and while idle.
// - Infrared select set routes data through encoder and decoder; idle low.
// - Infrared receive idles low; feature bit 2 inverts it before decoding.
// - User-output bit set drives user pin low and enables interrupt pin.
// - User-output bit clear floats interrupt pin and drives user pin high.
// - Clear-to-send is a readable input and optional automatic transmit gate.
// - Terminal-ready and request-to-send are active-low software outputs.
// - Set-ready, carrier and ring are readable inputs with no serial effect.
// - Request-to-send can be half-duplex direction, polarity selectable.
// - Bus isolate input makes all bus activity ignored.
// - Direction goes receive after each frame's stop bit, transmit when the shifter starts a frame.
// - Direction control off after reset; high receive, low transmit.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.

`timescale 1ns/1ps
`default_nettype none

module fifo_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wrPtr_q;
	logic [PW-1:0]    rdPtr_q;
	logic [PW:0]      count_q;
	logic             push;
	logic             pop;

	assign inReady  = (count_q != (PW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem_q[rdPtr_q];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == PW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == PW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule

module uart_serial_modem_pin_logic #(
	parameter int BIT_LEN = serial_pin_pkg::BIT_CYCLES,
	parameter int FDEPTH  = serial_pin_pkg::FIFO_DEPTH
) (
	input  wire logic                              clock,
	input  wire logic                              rstn,
	input  wire logic [serial_pin_pkg::ADDR_W-1:0] address,
	input  wire logic                              read,
	input  wire logic                              write,
	input  wire logic [serial_pin_pkg::DATA_W-1:0] writedata,
	input  wire logic [3:0]                        byteenable,
	output logic      [serial_pin_pkg::DATA_W-1:0] readdata,
	output logic                                   waitrequest,
	input  wire logic                              bus_isolate_in,
	input  wire logic                              irq_in_ch0,
	input  wire logic                              irq_in_ch1,
	output logic                                   irq_out_ch0,
	output logic                                   irq_out_oe_ch0,
	output logic                                   irq_out_ch1,
	output logic                                   irq_out_oe_ch1,
	output logic                                   serial_tx_out_ch0,
	output logic                                   serial_tx_out_ch1,
	input  wire logic                              serial_rx_in_ch0,
	input  wire logic                              serial_rx_in_ch1,
	output logic                                   req_to_send_n_ch0,
	output logic                                   req_to_send_n_ch1,
	input  wire logic                              clear_to_send_n_ch0,
	input  wire logic                              clear_to_send_n_ch1,
	output logic                                   terminal_ready_n_ch0,
	output logic                                   terminal_ready_n_ch1,
	input  wire logic                              set_ready_n_ch0,
	input  wire logic                              set_ready_n_ch1,
	input  wire logic                              carrier_detect_n_ch0,
	input  wire logic                              carrier_detect_n_ch1,
	input  wire logic                              ring_indicate_n_ch0,
	input  wire logic                              ring_indicate_n_ch1,
	output logic                                   user_out_n_ch0,
	output logic                                   user_out_n_ch1
);
	import serial_pin_pkg::*;

	localparam int PHW = (BIT_LEN > 1) ? $clog2(BIT_LEN) : 1;
	localparam int IRP = (BIT_LEN * 3 / 16 < 1) ? 1 : BIT_LEN * 3 / 16;

	logic [7:0]  modem_control_reg_q    [CHANNELS];
	logic [7:0]  feature_control_reg_q  [CHANNELS];
	logic [7:0]  enhanced_feature_reg_q [CHANNELS];
	logic [7:0]  extended_mode_reg_q    [CHANNELS];
	logic [7:0]  status_q               [CHANNELS];
	logic        txPin_q                [CHANNELS];
	logic        rtsPin_q               [CHANNELS];
	logic        dtrPin_q               [CHANNELS];
	logic        userPin_q              [CHANNELS];
	logic        irqPin_q               [CHANNELS];
	logic        irqOe_q                [CHANNELS];
	logic        fifoInReady            [CHANNELS];
	logic        fifoOutValid           [CHANNELS];
	logic        fifoOutReady           [CHANNELS];
	logic [7:0]  fifoOutData            [CHANNELS];
	logic        rxIn                   [CHANNELS];
	logic        ctsIn                  [CHANNELS];
	logic        dsrIn                  [CHANNELS];
	logic        cdIn                   [CHANNELS];
	logic        riIn                   [CHANNELS];
	logic        irqIn                  [CHANNELS];

	logic [DATA_W-1:0] readdata_q;
	logic              waitrequest_q;
	logic [2:0]        regSel;
	logic              chanSel;
	logic              isolated;
	logic              txFull;
	logic              ack;
	logic              doWrite;

	assign rxIn  = '{serial_rx_in_ch0, serial_rx_in_ch1};
	assign ctsIn = '{clear_to_send_n_ch0, clear_to_send_n_ch1};
	assign dsrIn = '{set_ready_n_ch0, set_ready_n_ch1};
	assign cdIn  = '{carrier_detect_n_ch0, carrier_detect_n_ch1};
	assign riIn  = '{ring_indicate_n_ch0, ring_indicate_n_ch1};
	assign irqIn = '{irq_in_ch0, irq_in_ch1};

	assign regSel   = address[4:2];
	assign chanSel  = address[CHAN_BIT];
	assign isolated = bus_isolate_in;
	// A full transmit buffer stalls the write instead of dropping the byte
	assign txFull   = write && !isolated && (regSel == REG_TX_DATA) && !fifoInReady[chanSel];
	assign ack      = (read || write) && waitrequest_q && !txFull;
	assign doWrite  = ack && write && !isolated && byteenable[0];

	// Answer one cycle after the request is seen, then re-arm
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			waitrequest_q <= 1'b1;
		end else begin
			waitrequest_q <= !ack;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			readdata_q <= '0;
		end else if (ack && read) begin
			readdata_q <= '0;
			if (isolated) begin
				readdata_q <= '0;
			end else if (regSel == REG_MODEM) begin
				readdata_q[7:0] <= modem_control_reg_q[chanSel];
			end else if (regSel == REG_FEATURE) begin
				readdata_q[7:0] <= feature_control_reg_q[chanSel];
			end else if (regSel == REG_ENHANCED) begin
				readdata_q[7:0] <= enhanced_feature_reg_q[chanSel];
			end else if (regSel == REG_EXTMODE) begin
				readdata_q[7:0] <= extended_mode_reg_q[chanSel];
			end else if (regSel == REG_STATUS) begin
				readdata_q[7:0] <= status_q[chanSel];
			end
		end
	end

	assign readdata    = readdata_q;
	assign waitrequest = waitrequest_q;

	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		tx_state_t  state_q;
		logic [9:0] shift_q;
		logic [3:0] bitCnt_q;
		logic [PHW-1:0] phase_q;
		logic       chWrite;
		logic       ctsBlock;
		logic       busy;
		logic       irMode;
		logic       rxLine;

		assign chWrite  = doWrite && (chanSel == 1'(ch));
		assign irMode   = modem_control_reg_q[ch][MC_IR_SELECT];
		assign ctsBlock = enhanced_feature_reg_q[ch][EF_AUTO_CTS] && ctsIn[ch];
		assign fifoOutReady[ch] = (state_q == TX_IDLE) && !ctsBlock;
		assign busy = (state_q == TX_SHIFT);
		// Decoder sees the optionally inverted line; a high pulse marks a zero bit
		assign rxLine = irMode ?
			!(rxIn[ch] ^ feature_control_reg_q[ch][FC_RX_INVERT]) : rxIn[ch];

		fifo_buffer #(
			.WIDTH (FIFO_WIDTH),
			.DEPTH (FDEPTH)
		) u_tx_fifo (
			.clock    (clock),
			.rstn     (rstn),
			.inValid  (chWrite && (regSel == REG_TX_DATA)),
			.inReady  (fifoInReady[ch]),
			.inData   (writedata[7:0]),
			.outValid (fifoOutValid[ch]),
			.outReady (fifoOutReady[ch]),
			.outData  (fifoOutData[ch])
		);

		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				modem_control_reg_q[ch]    <= REG_RESET;
				feature_control_reg_q[ch]  <= REG_RESET;
				enhanced_feature_reg_q[ch] <= REG_RESET;
				extended_mode_reg_q[ch]    <= REG_RESET;
			end else if (chWrite) begin
				if (regSel == REG_MODEM) begin
					modem_control_reg_q[ch] <= writedata[7:0];
				end else if (regSel == REG_FEATURE) begin
					feature_control_reg_q[ch] <= writedata[7:0];
				end else if (regSel == REG_ENHANCED) begin
					enhanced_feature_reg_q[ch] <= writedata[7:0];
				end else if (regSel == REG_EXTMODE) begin
					extended_mode_reg_q[ch] <= writedata[7:0];
				end
			end
		end

		// Start, eight data bits LSB first, one stop bit
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				state_q  <= TX_IDLE;
				shift_q  <= '1;
				bitCnt_q <= '0;
				phase_q  <= '0;
			end else begin
				case (state_q)
					TX_IDLE: begin
						if (fifoOutValid[ch] && fifoOutReady[ch]) begin
							state_q  <= TX_SHIFT;
							shift_q  <= {1'b1, fifoOutData[ch], 1'b0};
							bitCnt_q <= '0;
							phase_q  <= '0;
						end
					end
					TX_SHIFT: begin
						if (phase_q == PHW'(BIT_LEN-1)) begin
							phase_q  <= '0;
							shift_q  <= {1'b1, shift_q[9:1]};
							bitCnt_q <= bitCnt_q + 1'b1;
							if (bitCnt_q == 4'(FRAME_BITS-1)) begin
								state_q <= TX_IDLE;
							end
						end else begin
							phase_q <= phase_q + 1'b1;
						end
					end
					default: state_q <= TX_IDLE;
				endcase
			end
		end

		// Pin stage; one cycle behind the shifter
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				txPin_q[ch] <= 1'b1;
			end else if (irMode) begin
				txPin_q[ch] <= busy && !shift_q[0] && (phase_q < PHW'(IRP));
			end else begin
				txPin_q[ch] <= busy ? shift_q[0] : 1'b1;
			end
		end

		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				rtsPin_q[ch] <= 1'b1;
				dtrPin_q[ch] <= 1'b1;
			end else begin
				dtrPin_q[ch] <= !modem_control_reg_q[ch][MC_TERM_READY];
				if (feature_control_reg_q[ch][FC_AUTO_DIR]) begin
					// Low while sending, high while receiving, unless inverted
					rtsPin_q[ch] <= !busy ^ extended_mode_reg_q[ch][EM_DIR_INVERT];
				end else begin
					rtsPin_q[ch] <= !modem_control_reg_q[ch][MC_REQ_SEND];
				end
			end
		end

		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				userPin_q[ch] <= 1'b1;
				irqOe_q[ch]   <= 1'b0;
				irqPin_q[ch]  <= 1'b0;
			end else begin
				userPin_q[ch] <= !modem_control_reg_q[ch][MC_USER_OUT];
				irqOe_q[ch]   <= modem_control_reg_q[ch][MC_USER_OUT];
				irqPin_q[ch]  <= irqIn[ch];
			end
		end

		// Modem inputs feed status; only clear-to-send also reaches the shifter, through EF_AUTO_CTS
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				status_q[ch] <= REG_RESET;
			end else begin
				status_q[ch]          <= '0;
				status_q[ch][ST_CTS]  <= !ctsIn[ch];
				status_q[ch][ST_DSR]  <= !dsrIn[ch];
				status_q[ch][ST_CD]   <= !cdIn[ch];
				status_q[ch][ST_RI]   <= !riIn[ch];
				status_q[ch][ST_RX]   <= rxLine;
				status_q[ch][ST_BUSY] <= busy;
			end
		end
	end

	assign serial_tx_out_ch0    = txPin_q[0];
	assign serial_tx_out_ch1    = txPin_q[1];
	assign req_to_send_n_ch0    = rtsPin_q[0];
	assign req_to_send_n_ch1    = rtsPin_q[1];
	assign terminal_ready_n_ch0 = dtrPin_q[0];
	assign terminal_ready_n_ch1 = dtrPin_q[1];
	assign user_out_n_ch0       = userPin_q[0];
	assign user_out_n_ch1       = userPin_q[1];
	assign irq_out_ch0          = irqPin_q[0];
	assign irq_out_ch1          = irqPin_q[1];
	assign irq_out_oe_ch0       = irqOe_q[0];
	assign irq_out_oe_ch1       = irqOe_q[1];
endmodule

`default_nettype wire

//--- tb/serial_pin_sva.sv
// Port-level checks of the pin logic.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module serial_pin_sva (
	input wire logic                              clock,
	input wire logic                              rstn,
	input wire logic                              read,
	input wire logic                              write,
	input wire logic [serial_pin_pkg::DATA_W-1:0] readdata,
	input wire logic                              waitrequest,
	input wire logic                              bus_isolate_in,
	input wire logic                              irq_in_ch0,
	input wire logic                              irq_out_ch0,
	input wire logic                              irq_out_oe_ch0,
	input wire logic                              irq_out_oe_ch1,
	input wire logic                              serial_tx_out_ch0,
	input wire logic                              req_to_send_n_ch0,
	input wire logic                              terminal_ready_n_ch0,
	input wire logic                              user_out_n_ch0,
	input wire logic                              user_out_n_ch1
);
	import serial_pin_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	ack_one_a: assert property (!waitrequest |=> waitrequest)
		else $error("ack longer than one cycle");
	read_ack_a: assert property (read && waitrequest |=> !waitrequest)
		else $error("read not answered next cycle");
	reset_idle_a: assert property ($rose(rstn) |-> serial_tx_out_ch0 && req_to_send_n_ch0
		&& terminal_ready_n_ch0 && user_out_n_ch0 && !irq_out_oe_ch0)
		else $error("pins not idle after reset");
	user_irq0_a: assert property (user_out_n_ch0 != irq_out_oe_ch0)
		else $error("user pin and irq enable disagree ch0");
	user_irq1_a: assert property (user_out_n_ch1 != irq_out_oe_ch1)
		else $error("user pin and irq enable disagree ch1");
	irq_follow_a: assert property (irq_out_oe_ch0 |-> irq_out_ch0 == $past(irq_in_ch0))
		else $error("irq output does not follow");
	iso_read_a: assert property (bus_isolate_in && read && waitrequest |=> readdata == '0)
		else $error("isolated read returned data");
	iso_write_a: assert property (bus_isolate_in && write && waitrequest
		|=> ##1 $stable(terminal_ready_n_ch0) && $stable(user_out_n_ch0))
		else $error("isolated write changed pins");
	pin_cause_a: assert property ($changed(terminal_ready_n_ch0)
		|| $changed(user_out_n_ch0) |-> $past(write, 2))
		else $error("pin changed without a write");
	cover property ($fell(serial_tx_out_ch0));
	cover property (irq_out_oe_ch0 && irq_out_ch0);
	cover property (write && waitrequest ##1 write && waitrequest);
endmodule
bind uart_serial_modem_pin_logic serial_pin_sva chk (
	.clock, .rstn, .read, .write, .readdata, .waitrequest, .bus_isolate_in, .irq_in_ch0,
	.irq_out_ch0, .irq_out_oe_ch0, .irq_out_oe_ch1, .serial_tx_out_ch0, .req_to_send_n_ch0,
	.terminal_ready_n_ch0, .user_out_n_ch0, .user_out_n_ch1);
`default_nettype wire

//--- tb/far_end.sv
// Far-end serial device of one channel.
// Assumes start, 8 data bits LSB first, stop, BIT_LEN clocks a bit.
`timescale 1ns/1ps
`default_nettype none
module far_end #(
	parameter int BIT_LEN = 4
) (
	input  wire logic       clock,
	input  wire logic       txLine,
	input  wire logic       irMode,
	output logic            rxLine,
	output logic      [7:0] gotByte,
	output int              gotCnt,
	output int              irPulses
);
	logic [7:0] sh;
	assign rxLine = !irMode;
	// One process per counter, so each output has a single driver
	initial begin
		irPulses = 0;
		forever begin
			@(posedge txLine);
			if (irMode) begin
				irPulses <= irPulses + 1;
			end
		end
	end
	initial begin
		gotCnt = 0;
		gotByte = 8'h00;
		sh = 8'h00;
		forever begin
			@(negedge txLine);
			if (!irMode) begin
				// Sample mid-bit
				repeat (BIT_LEN / 2) @(posedge clock);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_LEN) @(posedge clock);
					sh[i] = txLine;
				end
				repeat (BIT_LEN) @(posedge clock);
				// Frames with a bad stop bit are dropped
				if (txLine) begin
					gotByte <= sh;
					gotCnt <= gotCnt + 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench of the two-channel pin logic.
// Assumes the package, the design and the far-end model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin nMismatch++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb;
	import serial_pin_pkg::*;
	localparam int BL = 4;
	logic        clock, rstn, read, write, isoIn;
	logic [5:0]  address;
	logic [31:0] writedata, q;
	logic [1:0]  irqIn, irMode;
	logic [7:0]  pinN;
	logic [7:0]  got [2];
	int          gotCnt [2], irPulses [2], nMismatch, numChecks;
	wire  [31:0] readdata;
	wire         waitrequest;
	wire  [1:0]  irqOut, irqOe, tx, rx, rtsN, dtrN, userN;
	uart_serial_modem_pin_logic #(.BIT_LEN(BL), .FDEPTH(FIFO_DEPTH)) DUT (
		.clock, .rstn, .address, .read, .write, .writedata, .byteenable(4'h1), .readdata,
		.waitrequest, .bus_isolate_in(isoIn), .irq_in_ch0(irqIn[0]), .irq_in_ch1(irqIn[1]),
		.irq_out_ch0(irqOut[0]), .irq_out_oe_ch0(irqOe[0]), .irq_out_ch1(irqOut[1]),
		.irq_out_oe_ch1(irqOe[1]), .serial_tx_out_ch0(tx[0]), .serial_tx_out_ch1(tx[1]),
		.serial_rx_in_ch0(rx[0]), .serial_rx_in_ch1(rx[1]), .req_to_send_n_ch0(rtsN[0]),
		.req_to_send_n_ch1(rtsN[1]), .clear_to_send_n_ch0(pinN[0]), .clear_to_send_n_ch1(pinN[4]),
		.terminal_ready_n_ch0(dtrN[0]), .terminal_ready_n_ch1(dtrN[1]),
		.set_ready_n_ch0(pinN[1]), .set_ready_n_ch1(pinN[5]), .carrier_detect_n_ch0(pinN[2]),
		.carrier_detect_n_ch1(pinN[6]), .ring_indicate_n_ch0(pinN[3]),
		.ring_indicate_n_ch1(pinN[7]), .user_out_n_ch0(userN[0]), .user_out_n_ch1(userN[1]));
	far_end #(.BIT_LEN(BL)) far0 (.clock, .txLine(tx[0]), .irMode(irMode[0]), .rxLine(rx[0]),
		.gotByte(got[0]), .gotCnt(gotCnt[0]), .irPulses(irPulses[0]));
	far_end #(.BIT_LEN(BL)) far1 (.clock, .txLine(tx[1]), .irMode(irMode[1]), .rxLine(rx[1]),
		.gotByte(got[1]), .gotCnt(gotCnt[1]), .irPulses(irPulses[1]));
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= {24'h0, d};
		do @(posedge clock); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(q, {24'h0, e})
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		nMismatch++;
		give_verdict();
	end
	initial begin
		rstn = 1'b0;
		{read, write, isoIn, irqIn, irMode} = '0;
		address = 6'h00;
		writedata = 32'h0;
		pinN = 8'hff;
		tick(16);
		rstn <= 1'b1;
		tick(1);
		`CHK({tx, rtsN, dtrN, userN, irqOe}, 10'h3fc)
		for (int i = 1; i < 5; i++) rd(6'(i * 4), 8'h00);
		bus(1'b1, 6'h04, 8'h0b);
		tick(2);
		`CHK({dtrN, rtsN, userN, irqOe}, 8'ha9)
		rd(6'h04, 8'h0b);
		irqIn <= 2'b11;
		tick(3);
		`CHK(irqOut, 2'b11)
		for (int i = 0; i < 4; i++) begin
			pinN <= ~(8'h01 << i);
			tick(3);
			rd(6'h14, 8'h10 | (8'h01 << i));
			rd(6'h34, 8'h10);
		end
		pinN <= 8'hff;
		rd(6'h1c, 8'h00);
		// Flow control on ch0 with the stop held: fills the buffer
		bus(1'b1, 6'h08, 8'h08);
		bus(1'b1, 6'h0c, 8'hc0);
		tick(2);
		`CHK(rtsN[0], 1'b1)
		for (int i = 0; i < 8; i++) bus(1'b1, 6'h00, {i[3:0], 4'h5});
		fork
			bus(1'b1, 6'h00, 8'h85);
			begin
				tick(12);
				`CHK({waitrequest, rtsN[0]}, 2'b11)
				pinN <= 8'hf0;
				tick(6);
				`CHK(rtsN[0], 1'b0)
			end
		join
		for (int i = 0; i < 9; i++) begin
			repeat (200) if (gotCnt[0] < i + 1) @(posedge clock);
			`CHK(got[0], {i[3:0], 4'h5})
		end
		tick(2 * BL);
		`CHK(rtsN[0], 1'b1)
		bus(1'b1, 6'h10, 8'h08);
		tick(2);
		`CHK(rtsN[0], 1'b0)
		irMode <= 2'b10;
		bus(1'b1, 6'h24, 8'h40);
		tick(2);
		`CHK(tx, 2'b01)
		rd(6'h34, 8'h10);
		bus(1'b1, 6'h28, 8'h04);
		tick(2);
		rd(6'h34, 8'h00);
		bus(1'b1, 6'h20, 8'h0f);
		rd(6'h34, 8'h20);
		tick(FRAME_BITS * BL + 8);
		`CHK({irPulses[1], tx[1]}, {32'd5, 1'b0})
		isoIn <= 1'b1;
		bus(1'b1, 6'h04, 8'h00);
		rd(6'h04, 8'h00);
		isoIn <= 1'b0;
		rd(6'h04, 8'h0b);
		bus(1'b1, 6'h04, 8'h03);
		tick(2);
		`CHK({userN, irqOe, dtrN[0]}, 5'b11000)
		give_verdict();
	end
endmodule
`default_nettype wire
